//--- include/pirq_pkg.sv
// Constants for the peripheral interrupt flag, enable and priority block
`default_nettype none
package pirq_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_FLAGS_SECOND = 8'h00;
  localparam logic [7:0] OFS_FLAGS_THIRD = 8'h04;
  localparam logic [7:0] OFS_EN_FIRST = 8'h08;
  localparam logic [7:0] OFS_EN_SECOND = 8'h0C;
  localparam logic [7:0] OFS_EN_THIRD = 8'h10;
  localparam logic [7:0] OFS_PRIO_FIRST = 8'h14;
  localparam logic [7:0] OFS_PRIO_SECOND = 8'h18;
  localparam logic [7:0] OFS_PRIO_THIRD = 8'h1C;
  localparam logic [7:0] OFS_CORE_CTRL = 8'h20;
  // Field positions
  localparam int BIT_OSC_FAIL = 7;
  localparam int BIT_COMPARATOR = 6;
  localparam int BIT_SERIAL1_COLL = 3;
  localparam int BIT_CAPCMP2 = 0;
  localparam int BIT_SERIAL2_DONE = 7;
  localparam int BIT_SERIAL2_COLL = 6;
  localparam int BIT_PARALLEL_PORT = 7;
  localparam int BIT_PRIO_LEVELS_ON = 2;
  localparam int BIT_PERIPH_GLOBAL_EN = 1;
  localparam int BIT_GLOBAL_IRQ_EN = 0;
  // Implemented-bit masks
  localparam logic [7:0] MASK_SECOND = 8'hC9;
  localparam logic [7:0] MASK_THIRD = 8'hC0;
  // Reset values
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'hFF;
  localparam logic [2:0] RST_CORE_CTRL = 3'h0;
  // Capture/compare modes
  typedef enum logic [1:0] {CC_CAPTURE, CC_COMPARE, CC_PWM, CC_OFF}
    capcmp_mode_e;
endpackage
`default_nettype wire

//--- hdl/pin_sync.sv
// Three-stage pin synchroniser with agreement check and rise pulse
`default_nettype none
module pin_sync
  import pirq_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Pin side
  input wire logic [WIDTH-1:0] pin_i,
  // Synchronous side
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o
);
  logic [WIDTH-1:0] s1, s2, s3;
  if (WIDTH < 1)
    $error("pin_sync: WIDTH must be at least 1");
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level_o <= '0;
    end
    else
    begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      // A change counts only once stages two and three agree
      level_o <= (s2 == s3) ? s3 : level_o;
    end
  assign rise_o = ((s2 == s3) ? s3 : level_o) & ~level_o;
endmodule
`default_nettype wire

//--- hdl/periph_irq.sv
// Peripheral interrupt flags, enables and priorities behind AHB-Lite
// Operation
// RULE_01 - Oscillator failure sets flag bit 7 of second flags; software clears.
// RULE_02 - Comparator input change sets bit 6 of second flags until cleared.
// RULE_03 - Serial port 1 collision sets bit 3 of second flags.
// RULE_04 - Capture or compare event sets bit 0; ignored in PWM mode.
// RULE_05 - Serial port 2 done sets bit 7 of third flags.
// RULE_06 - Serial port 2 collision sets bit 6 of third flags.
// RULE_07 - Unimplemented bits of all these registers read zero.
// RULE_08 - Enable bit beside each flag allows (1) or blocks (0) it.
// RULE_09 - Without priority levels, peripheral global enable must also be set.
// RULE_10 - Priority bit beside each flag: 1 high, 0 low.
// RULE_11 - Priority bits only matter while priority levels are on.
// RULE_12 - First enable/priority bits 7..0 map the eight first-group sources.
// RULE_13 - On 28-pin variant, bit 7 of first enable/priority reads zero.
// RULE_14 - Flags set regardless of enables so software can poll.
// RULE_15 - With levels on, low global enable gates low-priority sources.
// RULE_16 - Software clears flags before enabling and after servicing.
// RULE_17 - Drive high or low request when enabled flag meets gating.
//
// The address map and the AHB-Lite slave port were decided locally.
`default_nettype none
module periph_irq
  import pirq_pkg::*;
#(
  parameter bit PINS_28 = 1'b0
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Second/third group event pins and capture/compare mode from peripherals
  input wire logic osc_fail_i,
  input wire logic comparator_change_i,
  input wire logic serial1_collision_i,
  input wire logic capcmp2_event_i,
  input wire logic [1:0] capcmp2_mode_i,
  input wire logic serial2_done_i,
  input wire logic serial2_collision_i,
  // First-group flags, kept in another register
  input wire logic [7:0] flags_first_i,
  // Requests to the core
  output logic irq_high_o,
  output logic irq_low_o
);
  logic [7:0] flags2, flags3, en1, en2, en3, pr1, pr2, pr3;
  logic [2:0] core_ctrl;
  logic [7:0] wr_addr;
  logic wr_pend;
  logic [5:0] ev_rise;
  logic [7:0] set2, set3;
  logic [7:0] mask_first;
  logic [23:0] pend, prio;
  logic prio_on, periph_en, glob_en, any_high, any_low;

  // Small package has no parallel port, so bit 7 of group one is absent
  localparam logic [7:0] MASK_FIRST = PINS_28 ? 8'h7F : 8'hFF;
  assign mask_first = MASK_FIRST; // RULE_13

  pin_sync #(.WIDTH(6)) u_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .pin_i({osc_fail_i, comparator_change_i, serial1_collision_i,
      capcmp2_event_i, serial2_done_i, serial2_collision_i}),
    .level_o(),
    .rise_o(ev_rise)
  );

  // Bus write address captured in the address phase
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (hready_i)
    begin
      wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
      wr_addr <= haddr_i[7:0];
    end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = wr_pend && (a == o);
  endfunction

  always_comb
  begin
    set2 = 8'h00;
    set3 = 8'h00;
    set2[BIT_OSC_FAIL] = ev_rise[5]; // RULE_01
    set2[BIT_COMPARATOR] = ev_rise[4]; // RULE_02
    set2[BIT_SERIAL1_COLL] = ev_rise[3]; // RULE_03
    set2[BIT_CAPCMP2] = ev_rise[2] &&
      (capcmp2_mode_i == CC_CAPTURE || capcmp2_mode_i == CC_COMPARE); // RULE_04
    set3[BIT_SERIAL2_DONE] = ev_rise[1]; // RULE_05
    set3[BIT_SERIAL2_COLL] = ev_rise[0]; // RULE_06
  end

  // Flags: a set in the clearing cycle wins; writing 1 can also set
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      flags2 <= RST_FLAGS;
      flags3 <= RST_FLAGS;
    end
    else
    begin
      flags2 <= ((hit(wr_addr, OFS_FLAGS_SECOND) ? hwdata_i[7:0] : flags2)
        | set2) & MASK_SECOND; // RULE_14
      flags3 <= ((hit(wr_addr, OFS_FLAGS_THIRD) ? hwdata_i[7:0] : flags3)
        | set3) & MASK_THIRD; // RULE_07
    end

  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      en1 <= RST_EN;
      en2 <= RST_EN;
      en3 <= RST_EN;
      pr1 <= RST_PRIO & MASK_FIRST;
      pr2 <= RST_PRIO & MASK_SECOND;
      pr3 <= RST_PRIO & MASK_THIRD;
      core_ctrl <= RST_CORE_CTRL;
    end
    else if (wr_pend)
    begin
      if (wr_addr == OFS_EN_FIRST)
        en1 <= hwdata_i[7:0] & mask_first; // RULE_12
      else if (wr_addr == OFS_EN_SECOND)
        en2 <= hwdata_i[7:0] & MASK_SECOND; // RULE_07
      else if (wr_addr == OFS_EN_THIRD)
        en3 <= hwdata_i[7:0] & MASK_THIRD;
      else if (wr_addr == OFS_PRIO_FIRST)
        pr1 <= hwdata_i[7:0] & mask_first; // RULE_13
      else if (wr_addr == OFS_PRIO_SECOND)
        pr2 <= hwdata_i[7:0] & MASK_SECOND;
      else if (wr_addr == OFS_PRIO_THIRD)
        pr3 <= hwdata_i[7:0] & MASK_THIRD;
      else if (wr_addr == OFS_CORE_CTRL)
        core_ctrl <= hwdata_i[2:0];
    end

  // Read data registered in the address phase: zero wait states
  // A read pipelined behind a write to the same register sees the old value
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
      hrdata_o <= 32'h0000_0000;
    else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i)
    begin
      if (haddr_i[7:0] == OFS_FLAGS_SECOND)
        hrdata_o <= {24'h00_0000, flags2};
      else if (haddr_i[7:0] == OFS_FLAGS_THIRD)
        hrdata_o <= {24'h00_0000, flags3};
      else if (haddr_i[7:0] == OFS_EN_FIRST)
        hrdata_o <= {24'h00_0000, en1};
      else if (haddr_i[7:0] == OFS_EN_SECOND)
        hrdata_o <= {24'h00_0000, en2};
      else if (haddr_i[7:0] == OFS_EN_THIRD)
        hrdata_o <= {24'h00_0000, en3};
      else if (haddr_i[7:0] == OFS_PRIO_FIRST)
        hrdata_o <= {24'h00_0000, pr1};
      else if (haddr_i[7:0] == OFS_PRIO_SECOND)
        hrdata_o <= {24'h00_0000, pr2};
      else if (haddr_i[7:0] == OFS_PRIO_THIRD)
        hrdata_o <= {24'h00_0000, pr3};
      else if (haddr_i[7:0] == OFS_CORE_CTRL)
        hrdata_o <= {29'h0000_0000, core_ctrl};
      else
        hrdata_o <= 32'h0000_0000;
    end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  assign prio_on = core_ctrl[BIT_PRIO_LEVELS_ON];
  assign periph_en = core_ctrl[BIT_PERIPH_GLOBAL_EN];
  assign glob_en = core_ctrl[BIT_GLOBAL_IRQ_EN];
  assign pend = {flags_first_i & en1 & mask_first, flags2 & en2,
    flags3 & en3}; // RULE_08
  assign prio = {pr1, pr2, pr3}; // RULE_10
  assign any_high = |(pend & prio);
  assign any_low = |(pend & ~prio);

  // Requests registered so they are glitch-free
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      irq_high_o <= 1'b0;
      irq_low_o <= 1'b0;
    end
    else if (prio_on)
    begin
      irq_high_o <= glob_en && any_high; // RULE_11
      irq_low_o <= glob_en && periph_en && any_low; // RULE_15
    end
    else
    begin
      irq_high_o <= glob_en && periph_en && |pend; // RULE_09 RULE_17
      irq_low_o <= 1'b0;
    end

  // No software write lands on the given flag register this cycle
  sequence flag_kept(logic [7:0] ofs);
    !(wr_pend && wr_addr == ofs);
  endsequence

  // Read address phase aimed above the last register
  sequence unmapped_read;
    hready_i && hsel_i && htrans_i[1] && !hwrite_i
      && haddr_i[7:0] > OFS_CORE_CTRL;
  endsequence

  flag_sticky_a: // RULE_01
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      flags2[BIT_OSC_FAIL] ##0 flag_kept(OFS_FLAGS_SECOND)
      |=> flags2[BIT_OSC_FAIL])
    else $error("osc fail flag dropped without a write");
  osc_sets_a: // RULE_01
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      ev_rise[5] |=> flags2[BIT_OSC_FAIL])
    else $error("osc fail flag not set");
  event_sets_a: // RULE_02
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      ev_rise[4] |=> flags2[BIT_COMPARATOR])
    else $error("comparator flag not set");
  coll1_sets_a: // RULE_03
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      ev_rise[3] |=> flags2[BIT_SERIAL1_COLL])
    else $error("collision flag not set");
  pwm_ignore_a: // RULE_04
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      !flags2[BIT_CAPCMP2] && capcmp2_mode_i == CC_PWM
      ##0 flag_kept(OFS_FLAGS_SECOND) |=> !flags2[BIT_CAPCMP2])
    else $error("capture flag set in pwm mode");
  capcmp_sets_a: // RULE_04
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      ev_rise[2] && (capcmp2_mode_i == CC_CAPTURE
      || capcmp2_mode_i == CC_COMPARE) |=> flags2[BIT_CAPCMP2])
    else $error("capture flag not set");
  done2_sets_a: // RULE_05
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      ev_rise[1] |=> flags3[BIT_SERIAL2_DONE])
    else $error("serial 2 done flag not set");
  coll2_sets_a: // RULE_06
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      ev_rise[0] |=> flags3[BIT_SERIAL2_COLL])
    else $error("serial 2 collision flag not set");
  unimpl_zero_a: // RULE_07
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      ((flags2 | en2 | pr2) & ~MASK_SECOND) == 8'h00
      && ((flags3 | en3 | pr3) & ~MASK_THIRD) == 8'h00)
    else $error("unimplemented bit set");
  level_gate_a: // RULE_09
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      !prio_on && !periph_en |=> !irq_high_o && !irq_low_o)
    else $error("request without peripheral enable");
  high_req_a: // RULE_17
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      prio_on && glob_en && any_high |=> irq_high_o)
    else $error("high request missing");
  low_gate_a: // RULE_15
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      prio_on && !periph_en |=> !irq_low_o)
    else $error("low request without low enable");
  pin28_a: // RULE_13
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      PINS_28 |-> !en1[BIT_PARALLEL_PORT] && !pr1[BIT_PARALLEL_PORT])
    else $error("parallel port bits present on small part");
  single_level_a: // RULE_11
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      !prio_on |=> !irq_low_o)
    else $error("low request while priority levels are off");
  prio_high_a: // RULE_10
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      prio_on && !any_high |=> !irq_high_o)
    else $error("high request without a high priority source");
  low_req_a: // RULE_15
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      prio_on && glob_en && periph_en && any_low |=> irq_low_o)
    else $error("low request missing");
  en_gate_a: // RULE_08
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      pend == 24'h00_0000 |=> !irq_high_o && !irq_low_o)
    else $error("request without an enabled flag");
  cmp_sticky_a: // RULE_02
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      flags2[BIT_COMPARATOR] ##0 flag_kept(OFS_FLAGS_SECOND)
      |=> flags2[BIT_COMPARATOR])
    else $error("comparator flag dropped without a write");
  done2_sticky_a: // RULE_05
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      flags3[BIT_SERIAL2_DONE] ##0 flag_kept(OFS_FLAGS_THIRD)
      |=> flags3[BIT_SERIAL2_DONE])
    else $error("serial 2 done flag dropped without a write");
  coll2_sticky_a: // RULE_06
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      flags3[BIT_SERIAL2_COLL] ##0 flag_kept(OFS_FLAGS_THIRD)
      |=> flags3[BIT_SERIAL2_COLL])
    else $error("serial 2 collision flag dropped without a write");
  read_unmapped_a: // RULE_07
    assert property (@(posedge clock_i) disable iff (!nrst_i)
      unmapped_read |=> hrdata_o == 32'h0000_0000)
    else $error("unmapped register read not zero");
endmodule
`default_nettype wire

//--- sim/periph_model.sv
// Peripheral-side model that raises event pins for a few cycles
`default_nettype none
module periph_model
(
  // Clock
  input wire logic clock_i,
  // Event requests from the bench, one bit per source
  input wire logic [5:0] fire_i,
  // Event pins towards the block, low when idle
  output var logic [5:0] pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] hold = 3'h0;
  initial pins_o = 6'h00;
  // Pins stay up five cycles so the three-stage synchroniser agrees
  always @(posedge clock_i)
  begin
    if (fire_i != 6'h00)
    begin
      pins_o <= fire_i;
      hold <= 3'h5;
    end
    else if (hold != 3'h0)
    begin
      hold <= hold - 3'h1;
      if (hold == 3'h1)
        pins_o <= 6'h00;
    end
  end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Register and request tests for the peripheral interrupt block
`default_nettype none
module tb_top
  import pirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, dummy;
  logic [31:0] hrdata28, rd28;
  logic hresp;
  logic [1:0] htrans = 2'b00, mode = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [5:0] fire = 6'h00, pins;
  logic [7:0] first = 8'h00;
  logic irq_hi, irq_lo;
  int num_errors = 0, check_count = 0;
  logic [7:0] ofs [8] = '{OFS_FLAGS_SECOND, OFS_FLAGS_THIRD, OFS_EN_FIRST,
    OFS_EN_SECOND, OFS_EN_THIRD, OFS_PRIO_FIRST, OFS_PRIO_SECOND,
    OFS_PRIO_THIRD};
  logic [7:0] rstv [8] = '{RST_FLAGS, RST_FLAGS, RST_EN, RST_EN, RST_EN,
    8'hFF, MASK_SECOND, MASK_THIRD};
  logic [7:0] mask [8] = '{MASK_SECOND, MASK_THIRD, 8'hFF, MASK_SECOND,
    MASK_THIRD, 8'hFF, MASK_SECOND, MASK_THIRD};
  initial forever #12.5 clock = ~clock;
  periph_model i_model (.clock_i(clock), .fire_i(fire), .pins_o(pins));
  periph_irq i_dut (.clock_i(clock), .nrst_i(nrst), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .osc_fail_i(pins[5]),
    .comparator_change_i(pins[4]), .serial1_collision_i(pins[3]),
    .capcmp2_event_i(pins[2]), .capcmp2_mode_i(mode),
    .serial2_done_i(pins[1]), .serial2_collision_i(pins[0]),
    .flags_first_i(first), .irq_high_o(irq_hi), .irq_low_o(irq_lo));
  // Small-package copy on the same bus, read back alongside the main one
  periph_irq #(.PINS_28(1'b1)) i_dut_small (.clock_i(clock),
    .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata28), .hreadyout_o(), .hresp_o(),
    .osc_fail_i(pins[5]), .comparator_change_i(pins[4]),
    .serial1_collision_i(pins[3]), .capcmp2_event_i(pins[2]),
    .capcmp2_mode_i(mode), .serial2_done_i(pins[1]),
    .serial2_collision_i(pins[0]), .flags_first_i(first),
    .irq_high_o(), .irq_low_o());
  task automatic end_of_test;
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  // One single-word transfer; waits on ready in both phases
  task automatic bus(input logic [7:0] a, input logic wr,
    input logic [31:0] wd, output logic [31:0] rd);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsel <= 1'b1;
    @(posedge clock);
    while (hready !== 1'b1)
      @(posedge clock);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clock);
    while (hready !== 1'b1)
      @(posedge clock);
    rd = hrdata;
    rd28 = hrdata28;
    check({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, {24'h0, d}, dummy);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    check(r, {24'h0, e});
  endtask
  task automatic irq_chk(input logic hi, input logic lo);
    repeat (3) @(posedge clock);
    check({30'h0, irq_hi, irq_lo}, {30'h0, hi, lo});
  endtask
  task automatic event_fire(input logic [5:0] b);
    fire <= b;
    @(posedge clock);
    fire <= 6'h00;
    repeat (12) @(posedge clock);
  endtask
  initial
  begin
    repeat (5000) @(posedge clock);
    num_errors++;
    end_of_test();
  end
  initial
  begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd_chk(ofs[i], rstv[i]);
    rd_chk(OFS_PRIO_FIRST, 8'hFF);
    check(rd28, 32'h0000_007F);
    for (int i = 0; i < 8; i++)
      wr(ofs[i], 8'hFF);
    wr(8'h24, 8'hFF);
    rd_chk(8'h24, 8'h00);
    for (int i = 0; i < 8; i++)
      rd_chk(ofs[i], mask[i]);
    rd_chk(OFS_EN_FIRST, 8'hFF);
    check(rd28, 32'h0000_007F);
    for (int i = 0; i < 8; i++)
      wr(ofs[i], 8'h00);
    mode <= CC_PWM;
    event_fire(6'h04);
    rd_chk(OFS_FLAGS_SECOND, 8'h00);
    mode <= CC_COMPARE;
    event_fire(6'h04);
    rd_chk(OFS_FLAGS_SECOND, 8'h01);
    mode <= CC_CAPTURE;
    event_fire(6'h3F);
    rd_chk(OFS_FLAGS_SECOND, 8'hC9);
    rd_chk(OFS_FLAGS_THIRD, 8'hC0);
    irq_chk(1'b0, 1'b0);
    wr(OFS_FLAGS_SECOND, 8'h80);
    rd_chk(OFS_FLAGS_SECOND, 8'h80);
    wr(OFS_EN_SECOND, 8'h80);
    wr(OFS_CORE_CTRL, 8'h01);
    irq_chk(1'b0, 1'b0);
    wr(OFS_CORE_CTRL, 8'h03);
    irq_chk(1'b1, 1'b0);
    wr(OFS_CORE_CTRL, 8'h05);
    irq_chk(1'b0, 1'b0);
    wr(OFS_CORE_CTRL, 8'h07);
    irq_chk(1'b0, 1'b1);
    wr(OFS_PRIO_SECOND, 8'h80);
    irq_chk(1'b1, 1'b0);
    wr(OFS_EN_SECOND, 8'h00);
    irq_chk(1'b0, 1'b0);
    first <= 8'h01;
    wr(OFS_EN_FIRST, 8'h01);
    irq_chk(1'b0, 1'b1);
    wr(OFS_FLAGS_SECOND, 8'h00);
    rd_chk(OFS_FLAGS_SECOND, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
